// ---- wk_wake_ctrl.sv ----
/*
 * wk_wake_ctrl: wake event detection and remote-wake request logic.
 * Gathers mac wake events, good frames, phy energy detect, pins and
 * phy link up into one internal wake interrupt, qualified by suspend mode.
 * assumes: mac, phy and usb core signals are on clk; gpio pins are not.
 * Register port: read data valid the cycle after the read strobe.
 */
// Decided for this implementation: the register offsets and the strobed register port.

// Summary of operation
// - gate mac events by enables, merge them
// - wake interrupt from lan, good frame, energy or pin paths
// - status bit0 energy, bit1 lan/good frame
// - lan wake only in suspend zero
// - energy wake only in suspend one
// - no lan enables: good frame wakes
// - good frame wake only in suspend three
// - wake interrupt raises remote-wake request
// - pins 0-10 wake in every suspend state, except pin7 in link-up mode
// - pins 8-10 qualified by function 00, input
// - per-pin wake bit and polarity level
// - pin7 link-up wake in modes 0, 3
// - link-up mode ignores pin7 level
// - pin wake returns normal, sets status
// - lan status bit sticky while event
// - energy status bit sticky while irq
// - separate seen flags for magic, pattern, exact, broadcast
// - suspend mode field, reset code 10
// - set pin status wakes at once

`timescale 1ns/100ps

module wk_wake_ctrl #(
    parameter int NUM_PINS = wk_pkg::NUM_PINS
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,

    // register port
    input  wire logic [wk_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [wk_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [wk_pkg::DATA_W-1:0]   reg_rdata,

    // mac and phy events
    input  wire logic [wk_pkg::NUM_MAC_EVT-1:0] mac_evt,
    input  wire logic                        good_frame,
    input  wire logic                        phy_irq,
    input  wire logic                        phy_link_up,

    // general purpose pins
    input  wire logic [NUM_PINS-1:0]         gpio_in,

    // usb core
    input  wire logic                        usb_suspend,
    input  wire logic                        usb_resume,
    output logic                             remote_wake,
    output logic                             suspended,
    output logic      [1:0]                  suspend_mode
);
    wk_pin_if #(.N(NUM_PINS)) pin_bus ();

    wk_pkg::wk_state_type state_ff;

    logic [1:0]                      status_ff;
    logic                            lan_en_ff;
    logic                            energy_en_ff;
    logic [1:0]                      mode_ff;
    logic [wk_pkg::NUM_MAC_EVT-1:0]  mac_en_ff;
    logic [3:0]                      seen_ff;
    logic [wk_pkg::NUM_LOW_PINS-1:0] low_en_ff;
    logic [2*wk_pkg::NUM_HIGH_PINS-1:0] func_ff;
    logic [wk_pkg::NUM_HIGH_PINS-1:0] dir_ff;
    logic [NUM_PINS-1:0]             wake_bit_ff;
    logic [NUM_PINS-1:0]             pol_ff;
    logic                            linkup_sel_ff;
    logic [NUM_PINS-1:0]             irq_ff;
    logic [wk_pkg::DATA_W-1:0]       rdata_ff;
    logic                            remote_wake_ff;

    logic                            wr_pwr;
    logic                            wr_mac;
    logic                            wr_irq;
    logic                            mac_wake;
    logic                            all_lan_off;
    logic                            lan_event;
    logic [NUM_PINS-1:0]             pin_qual;
    logic [NUM_PINS-1:0]             pin_allowed;
    logic                            lan_wake;
    logic                            energy_wake;
    logic                            frame_wake;
    logic                            pin_wake;
    logic                            wake_req;
    logic [wk_pkg::DATA_W-1:0]       nxt_rdata;

    assign wr_pwr = reg_wr && (reg_addr == wk_pkg::REG_PWR_CTRL);
    assign wr_mac = reg_wr && (reg_addr == wk_pkg::REG_MAC_WAKE);
    assign wr_irq = reg_wr && (reg_addr == wk_pkg::REG_IRQ_STATUS);

    // mac wake sources
    assign mac_wake = |(mac_evt & mac_en_ff);
    assign all_lan_off = (mac_en_ff == '0);
    // frames passing the filters count only with every lan enable clear
    assign lan_event = mac_wake || (good_frame && all_lan_off);

    // pin qualification
    always_comb begin
        pin_qual = '0;
        for (int i = 0; i < wk_pkg::NUM_LOW_PINS; i++) begin
            pin_qual[i] = !low_en_ff[i] && wake_bit_ff[i];
        end
        for (int j = 0; j < wk_pkg::NUM_HIGH_PINS; j++) begin
            pin_qual[wk_pkg::NUM_LOW_PINS + j] = wake_bit_ff[wk_pkg::NUM_LOW_PINS + j] &&
                (func_ff[2*j +: 2] == wk_pkg::LED_FUNC_GPIO) && !dir_ff[j];
        end
    end

    assign pin_bus.pin_raw = gpio_in;
    assign pin_bus.qualified = pin_qual;
    assign pin_bus.polarity = pol_ff;
    assign pin_bus.linkup_sel = linkup_sel_ff;
    assign pin_bus.link_up = phy_link_up;

    wk_pin_det #(
        .N        (NUM_PINS),
        .LINK_PIN (wk_pkg::LINKUP_PIN)
    ) u_pin_det (
        .clk  (clk),
        .nrst (nrst),
        .pins (pin_bus.det)
    );

    // status bits: set wins over a write-one clear, and a clear is refused
    // while the source still stands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_ff <= '0;
        end else begin
            if (phy_irq) begin
                status_ff[wk_pkg::STATUS_ENERGY] <= 1'b1;
            end else if (wr_pwr && reg_wdata[wk_pkg::PWR_STATUS_LSB + wk_pkg::STATUS_ENERGY]) begin
                status_ff[wk_pkg::STATUS_ENERGY] <= 1'b0;
            end
            if (lan_event) begin
                status_ff[wk_pkg::STATUS_LAN] <= 1'b1;
            end else if (wr_pwr && !mac_wake &&
                         reg_wdata[wk_pkg::PWR_STATUS_LSB + wk_pkg::STATUS_LAN]) begin
                status_ff[wk_pkg::STATUS_LAN] <= 1'b0;
            end
        end
    end

    // power control fields
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lan_en_ff <= 1'b0;
            energy_en_ff <= 1'b0;
            mode_ff <= wk_pkg::MODE_RESET;
        end else if (wr_pwr) begin
            lan_en_ff <= reg_wdata[wk_pkg::PWR_LAN_EN_BIT];
            energy_en_ff <= reg_wdata[wk_pkg::PWR_ENERGY_EN_BIT];
            mode_ff <= reg_wdata[wk_pkg::PWR_MODE_LSB +: 2];
        end
    end

    // mac wake enables and seen flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mac_en_ff <= '0;
        end else if (wr_mac) begin
            mac_en_ff <= reg_wdata[wk_pkg::MWK_EN_LSB +: wk_pkg::NUM_MAC_EVT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seen_ff <= '0;
        end else begin
            // bits: magic, pattern, exact, broadcast
            for (int k = 0; k < 4; k++) begin
                if (mac_evt[k + 1] && mac_en_ff[k + 1]) begin
                    seen_ff[k] <= 1'b1;
                end else if (wr_mac && reg_wdata[wk_pkg::MWK_SEEN_LSB + k]) begin
                    seen_ff[k] <= 1'b0;
                end
            end
        end
    end

    // pin configuration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_en_ff <= wk_pkg::PIN_LOW_EN_RESET;
        end else if (reg_wr && (reg_addr == wk_pkg::REG_PIN_CFG)) begin
            low_en_ff <= reg_wdata[wk_pkg::NUM_LOW_PINS-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            func_ff <= '0;
            dir_ff <= wk_pkg::PIN_DIR_RESET;
        end else if (reg_wr && (reg_addr == wk_pkg::REG_LED_PIN_CFG)) begin
            func_ff <= reg_wdata[wk_pkg::LED_FUNC_LSB +: 2*wk_pkg::NUM_HIGH_PINS];
            dir_ff <= reg_wdata[wk_pkg::LED_DIR_LSB +: wk_pkg::NUM_HIGH_PINS];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_bit_ff <= '0;
            pol_ff <= '0;
            linkup_sel_ff <= 1'b0;
        end else if (reg_wr && (reg_addr == wk_pkg::REG_PIN_WAKE)) begin
            wake_bit_ff <= reg_wdata[wk_pkg::PWK_WAKE_LSB +: NUM_PINS];
            pol_ff <= reg_wdata[wk_pkg::PWK_POL_LSB +: NUM_PINS];
            linkup_sel_ff <= reg_wdata[wk_pkg::PWK_LINKUP_BIT];
        end
    end

    // pin interrupt status, write one to clear, a new hit wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_ff <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                if (pin_bus.hit[p]) begin
                    irq_ff[p] <= 1'b1;
                end else if (wr_irq && reg_wdata[p]) begin
                    irq_ff[p] <= 1'b0;
                end
            end
        end
    end

    // suspend-state qualification of each source
    always_comb begin
        pin_allowed = '1;
        if (linkup_sel_ff && !((mode_ff == wk_pkg::MODE_SUSPEND0) ||
                               (mode_ff == wk_pkg::MODE_SUSPEND3))) begin
            pin_allowed[wk_pkg::LINKUP_PIN] = 1'b0;
        end
    end

    assign lan_wake = status_ff[wk_pkg::STATUS_LAN] && lan_en_ff && !all_lan_off &&
        (mode_ff == wk_pkg::MODE_SUSPEND0);
    assign frame_wake = status_ff[wk_pkg::STATUS_LAN] && all_lan_off &&
        (mode_ff == wk_pkg::MODE_SUSPEND3);
    assign energy_wake = status_ff[wk_pkg::STATUS_ENERGY] && energy_en_ff &&
        (mode_ff == wk_pkg::MODE_SUSPEND1);
    // any pin status left set wakes straight away, except link-up pin 7 outside suspend 0 and 3
    assign pin_wake = |(irq_ff & pin_allowed);
    assign wake_req = lan_wake || frame_wake || energy_wake || pin_wake;

    // device power state
    // host resume ends suspend without a request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= wk_pkg::WK_NORMAL;
        end else begin
            unique case (state_ff)
                wk_pkg::WK_NORMAL: begin
                    if (usb_suspend) begin
                        state_ff <= wk_pkg::WK_SUSPENDED;
                    end
                end
                wk_pkg::WK_SUSPENDED: begin
                    if (wake_req || usb_resume) begin
                        state_ff <= wk_pkg::WK_NORMAL;
                    end
                end
            endcase
        end
    end

    // one-cycle request, only from the suspended state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remote_wake_ff <= 1'b0;
        end else begin
            remote_wake_ff <= (state_ff == wk_pkg::WK_SUSPENDED) && wake_req;
        end
    end

    // register read, data the cycle after the strobe, zero otherwise
    always_comb begin
        nxt_rdata = '0;
        unique case (reg_addr)
            wk_pkg::REG_PWR_CTRL: begin
                nxt_rdata[wk_pkg::PWR_STATUS_LSB +: 2] = status_ff;
                nxt_rdata[wk_pkg::PWR_LAN_EN_BIT] = lan_en_ff;
                nxt_rdata[wk_pkg::PWR_ENERGY_EN_BIT] = energy_en_ff;
                nxt_rdata[wk_pkg::PWR_MODE_LSB +: 2] = mode_ff;
                nxt_rdata[wk_pkg::PWR_SUSPENDED_BIT] = (state_ff == wk_pkg::WK_SUSPENDED);
            end
            wk_pkg::REG_MAC_WAKE: begin
                nxt_rdata[wk_pkg::MWK_EN_LSB +: wk_pkg::NUM_MAC_EVT] = mac_en_ff;
                nxt_rdata[wk_pkg::MWK_SEEN_LSB +: 4] = seen_ff;
            end
            wk_pkg::REG_PIN_CFG: begin
                nxt_rdata[wk_pkg::NUM_LOW_PINS-1:0] = low_en_ff;
            end
            wk_pkg::REG_LED_PIN_CFG: begin
                nxt_rdata[wk_pkg::LED_FUNC_LSB +: 2*wk_pkg::NUM_HIGH_PINS] = func_ff;
                nxt_rdata[wk_pkg::LED_DIR_LSB +: wk_pkg::NUM_HIGH_PINS] = dir_ff;
            end
            wk_pkg::REG_PIN_WAKE: begin
                nxt_rdata[wk_pkg::PWK_WAKE_LSB +: NUM_PINS] = wake_bit_ff;
                nxt_rdata[wk_pkg::PWK_POL_LSB +: NUM_PINS] = pol_ff;
                nxt_rdata[wk_pkg::PWK_LINKUP_BIT] = linkup_sel_ff;
            end
            wk_pkg::REG_IRQ_STATUS: begin
                nxt_rdata[NUM_PINS-1:0] = irq_ff;
            end
            default: begin
                nxt_rdata = '0;
            end
        endcase
    end

    // zero between reads: no stale word on the bus
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign remote_wake = remote_wake_ff;
    assign suspended = (state_ff == wk_pkg::WK_SUSPENDED);
    assign suspend_mode = mode_ff;
endmodule

// ---- wk_pkg.sv ----
/*
 * wk_pkg: shared constants of the wake event and remote-wake block:
 * register offsets, field positions, reset values and suspend-mode codes.
 * assumes: included by name only, no import; byte addresses on an
 * 8-bit register port with 32-bit data.
 */
package wk_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_PINS = 11;
    localparam int NUM_LOW_PINS = 8;
    localparam int NUM_HIGH_PINS = 3;
    localparam int LINKUP_PIN = 7;
    localparam int NUM_MAC_EVT = 5;

    // register byte offsets
    localparam logic [7:0] REG_PWR_CTRL = 8'h00;
    localparam logic [7:0] REG_MAC_WAKE = 8'h04;
    localparam logic [7:0] REG_PIN_CFG = 8'h08;
    localparam logic [7:0] REG_LED_PIN_CFG = 8'h0c;
    localparam logic [7:0] REG_PIN_WAKE = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h14;

    // power_mgmt_ctrl fields
    localparam int PWR_STATUS_LSB = 0;
    localparam int PWR_LAN_EN_BIT = 2;
    localparam int PWR_ENERGY_EN_BIT = 3;
    localparam int PWR_MODE_LSB = 4;
    localparam int PWR_SUSPENDED_BIT = 8;
    localparam int STATUS_ENERGY = 0;
    localparam int STATUS_LAN = 1;

    // mac_wake_ctrl_stat fields
    localparam int MWK_EN_LSB = 0;
    localparam int MWK_SEEN_LSB = 5;

    // mac event order, also the enable bit order
    localparam int EVT_UNICAST = 0;
    localparam int EVT_MAGIC = 1;
    localparam int EVT_PATTERN = 2;
    localparam int EVT_EXACT = 3;
    localparam int EVT_BCAST = 4;

    // led_pin_config fields: function field 2 bits per pin, direction bits
    localparam int LED_FUNC_LSB = 0;
    localparam int LED_DIR_LSB = 8;
    localparam logic [1:0] LED_FUNC_GPIO = 2'h0;

    // pin wake register fields
    localparam int PWK_WAKE_LSB = 0;
    localparam int PWK_POL_LSB = 16;
    localparam int PWK_LINKUP_BIT = 31;

    // suspend mode codes
    localparam logic [1:0] MODE_SUSPEND0 = 2'h0;
    localparam logic [1:0] MODE_SUSPEND1 = 2'h1;
    localparam logic [1:0] MODE_SUSPEND2 = 2'h2;
    localparam logic [1:0] MODE_SUSPEND3 = 2'h3;
    localparam logic [1:0] MODE_RESET = MODE_SUSPEND2;

    // reset values
    localparam logic [7:0] PIN_LOW_EN_RESET = 8'hff;
    localparam logic [2:0] PIN_DIR_RESET = 3'h7;

    typedef enum logic {
        WK_NORMAL,
        WK_SUSPENDED
    } wk_state_type;

endpackage

// ---- wk_pin_if.sv ----
/*
 * wk_pin_if: carries pin configuration into the pin detector and its
 * per-pin hits back out.
 * assumes: one detector and one controller share a single clock.
 */
`timescale 1ns/100ps

interface wk_pin_if #(
    parameter int N = 11
);
    logic [N-1:0] pin_raw;
    logic [N-1:0] qualified;
    logic [N-1:0] polarity;
    logic         linkup_sel;
    logic         link_up;
    logic [N-1:0] hit;

    modport ctrl (
        output qualified,
        output polarity,
        output linkup_sel,
        output link_up,
        output pin_raw,
        input  hit
    );

    modport det (
        input  qualified,
        input  polarity,
        input  linkup_sel,
        input  link_up,
        input  pin_raw,
        output hit
    );
endinterface

// ---- wk_pin_det.sv ----
/*
 * wk_pin_det: synchronises the general purpose pins and reports each
 * qualified pin sitting at its chosen wake level.
 * assumes: pins are asynchronous; link_up is on the clk domain.
 */
`timescale 1ns/100ps

module wk_pin_det #(
    parameter int N = 11,
    parameter int LINK_PIN = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pin side
    wk_pin_if.det    pins
);
    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] level;

    // two flops before any logic looks at a pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pins.pin_raw;
            sync_ff <= meta_ff;
        end
    end

    always_comb begin
        level = sync_ff;
        // link-up mode replaces the pin level; polarity is bypassed too
        if (pins.linkup_sel) begin
            level[LINK_PIN] = pins.link_up;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_hit
            if (i == LINK_PIN) begin : g_link
                assign pins.hit[i] = pins.qualified[i] &&
                    (pins.linkup_sel ? level[i] : (level[i] == pins.polarity[i]));
            end else begin : g_plain
                assign pins.hit[i] = pins.qualified[i] && (level[i] == pins.polarity[i]);
            end
        end
    endgenerate
endmodule

// ---- wk_wake_props.sv ----
/*
 * wk_wake_props: concurrent checks on the ports of wk_wake_ctrl.
 * assumes: one clock domain; enables mirror the register writes.
 */
`timescale 1ns/100ps

module wk_wake_props #(
    parameter int NUM_PINS = wk_pkg::NUM_PINS
) (
    // clock and reset
    input wire logic                            clk,
    input wire logic                            nrst,
    // register port
    input wire logic [wk_pkg::ADDR_W-1:0]       reg_addr,
    input wire logic [wk_pkg::DATA_W-1:0]       reg_wdata,
    input wire logic                            reg_wr,
    input wire logic                            reg_rd,
    input wire logic [wk_pkg::DATA_W-1:0]       reg_rdata,
    // events
    input wire logic [wk_pkg::NUM_MAC_EVT-1:0]  mac_evt,
    input wire logic                            good_frame,
    input wire logic                            phy_irq,
    input wire logic                            phy_link_up,
    input wire logic [NUM_PINS-1:0]             gpio_in,
    // usb core
    input wire logic                            usb_suspend,
    input wire logic                            usb_resume,
    input wire logic                            remote_wake,
    input wire logic                            suspended,
    input wire logic [1:0]                      suspend_mode
);
    logic [1:0] pwr_en_ff;
    logic [4:0] mac_en_ff;
    wire        pwr_wr  = reg_wr && reg_addr == wk_pkg::REG_PWR_CTRL;
    wire        mac_wr  = reg_wr && reg_addr == wk_pkg::REG_MAC_WAKE;
    wire [1:0]  wr_mode = reg_wdata[5:4];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) pwr_en_ff <= 2'h0;
        else if (pwr_wr) pwr_en_ff <= reg_wdata[3:2];
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) mac_en_ff <= 5'h00;
        else if (mac_wr) mac_en_ff <= reg_wdata[4:0];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // a one-cycle request that coincides with leaving suspend
    sequence s_wake;
        ##[1:3] (remote_wake && !suspended) ##1 !remote_wake;
    endsequence

    property p_energy;
        suspended && suspend_mode == wk_pkg::MODE_SUSPEND1 && pwr_en_ff[1] && phy_irq |-> s_wake;
    endproperty
    a_energy: assert property (p_energy) else $error("energy wake missing");
    property p_lan;
        suspended && suspend_mode == wk_pkg::MODE_SUSPEND0 && pwr_en_ff[0]
            && (mac_evt & mac_en_ff) != 5'h00 |-> s_wake;
    endproperty
    a_lan: assert property (p_lan) else $error("lan wake missing");
    property p_gframe;
        suspended && suspend_mode == wk_pkg::MODE_SUSPEND3 && mac_en_ff == 5'h00
            && good_frame |-> s_wake;
    endproperty
    a_gframe: assert property (p_gframe) else $error("good frame wake missing");
    property p_rw_susp;
        remote_wake |-> $past(suspended);
    endproperty
    a_rw_susp: assert property (p_rw_susp) else $error("wake while normal");
    property p_rw_exit;
        remote_wake |-> !suspended;
    endproperty
    a_rw_exit: assert property (p_rw_exit) else $error("wake without leaving");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_mode_rst;
        $rose(nrst) |-> suspend_mode == wk_pkg::MODE_RESET && !suspended && !remote_wake;
    endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("bad reset state");
    property p_mode_wr;
        pwr_wr |=> suspend_mode == $past(wr_mode);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode not written");
    property p_susp_in;
        !suspended && usb_suspend && !usb_resume |=> suspended;
    endproperty
    a_susp_in: assert property (p_susp_in) else $error("suspend not entered");
    property p_resume;
        suspended && usb_resume |=> !suspended;
    endproperty
    a_resume: assert property (p_resume) else $error("resume not taken");
endmodule

bind wk_wake_ctrl wk_wake_props #(.NUM_PINS(NUM_PINS)) u_props (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mac_evt,
    .good_frame, .phy_irq, .phy_link_up, .gpio_in, .usb_suspend, .usb_resume,
    .remote_wake, .suspended, .suspend_mode
);

// ---- wk_usb_host.sv ----
/*
 * wk_usb_host: usb host side seen by the wake block: suspend and resume
 * signalling on request, and a count of remote-wake requests.
 * assumes: requests come from the bench on clk; the host never resumes
 * on its own, so a missing wake stays visible.
 */
`timescale 1ns/100ps

module wk_usb_host (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // bench requests
    input  wire logic go_suspend,
    input  wire logic go_resume,
    // device side
    input  wire logic remote_wake,
    output logic      usb_suspend,
    output logic      usb_resume,
    output int        wakes
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usb_suspend <= 1'b0;
            usb_resume  <= 1'b0;
            wakes       <= 0;
        end else begin
            usb_suspend <= go_suspend;
            usb_resume  <= go_resume;
            if (remote_wake) wakes <= wakes + 1;
        end
    end
endmodule

// ---- testbench.sv ----
/*
 * testbench: register-driven tests of wk_wake_ctrl with a host model.
 * assumes: wk_pkg offsets; pin levels outlast the two-flop synchroniser.
 */
`timescale 1ns/100ps

module testbench;
    logic        clk, nrst, reg_wr, reg_rd, good_frame, phy_irq, phy_link_up;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [4:0]  mac_evt;
    logic [10:0] gpio_in;
    logic        go_susp, go_res, usb_suspend, usb_resume, remote_wake, suspended;
    logic [1:0]  suspend_mode;
    int          wakes, fails, tests_run, w0;
    localparam logic [7:0]  RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    localparam logic [31:0] RV [7] = '{32'h20, 32'h0, 32'hff, 32'h700, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] SEEN [5] = '{32'h0, 32'h20, 32'h40, 32'h80, 32'h100};

    wk_wake_ctrl DUT (
        .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mac_evt,
        .good_frame, .phy_irq, .phy_link_up, .gpio_in, .usb_suspend, .usb_resume,
        .remote_wake, .suspended, .suspend_mode
    );
    wk_usb_host u_host (
        .clk, .nrst, .go_suspend(go_susp), .go_resume(go_res), .remote_wake,
        .usb_suspend, .usb_resume, .wakes
    );

    always #20 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic host_pulse(input logic res);
        @(posedge clk);
        if (res) go_res <= 1'b1;
        else go_susp <= 1'b1;
        @(posedge clk);
        go_res  <= 1'b0;
        go_susp <= 1'b0;
        tick(2);
    endtask

    // one event kind in one suspend mode; kinds 0 energy 1 lan 2 frame 3 link 4 pin9
    task automatic trial(input logic [1:0] m, input int k);
        logic ok;
        ok = (k == 0 && m == 1) || (k == 1 && m == 0) || (k == 2 && m == 3)
            || (k == 3 && (m == 0 || m == 3)) || k == 4;
        wr(wk_pkg::REG_MAC_WAKE, k == 1 ? 32'h2 : 32'h0);
        wr(wk_pkg::REG_PIN_CFG, k == 3 ? 32'h7f : 32'hff);
        wr(wk_pkg::REG_PIN_WAKE, k == 3 ? 32'h8000_0080 : (k == 4 ? 32'h0200_0200 : 32'h0));
        wr(wk_pkg::REG_IRQ_STATUS, 32'h7ff);
        wr(wk_pkg::REG_PWR_CTRL, {26'h0, m, 4'hf});
        w0 = wakes;
        host_pulse(1'b0);
        chk(32'(suspended), 32'h1, "suspend entry");
        @(posedge clk);
        case (k)
            0: phy_irq <= 1'b1;
            1: mac_evt <= 5'h02;
            2: good_frame <= 1'b1;
            3: phy_link_up <= 1'b1;
            default: gpio_in[9] <= 1'b1;
        endcase
        tick(3);
        {phy_irq, good_frame, phy_link_up} <= 3'h0;
        mac_evt <= 5'h00;
        gpio_in <= 11'h000;
        tick(6);
        chk(32'(wakes - w0), 32'(ok), "wake count");
        chk(32'(suspended), 32'(!ok), "state after event");
        if (k >= 3) begin
            rd(wk_pkg::REG_IRQ_STATUS);
            chk(d, k == 3 ? 32'h80 : 32'h200, "pin status");
        end
        if (suspended === 1'b1) host_pulse(1'b1);
    endtask

    initial begin
        {clk, nrst, reg_wr, reg_rd, good_frame, phy_irq, phy_link_up, go_susp, go_res} = '0;
        {reg_addr, reg_wdata, mac_evt, gpio_in} = '0;
        fails = 0;
        tests_run = 0;
        tick(3);
        nrst <= 1'b1;
        wr(8'h18, 32'hffff_ffff);
        for (int i = 0; i < 7; i++) begin
            rd(RA[i]);
            chk(d, RV[i], "reset or unmapped value");
        end
        wr(wk_pkg::REG_LED_PIN_CFG, 32'h0500);
        wr(wk_pkg::REG_MAC_WAKE, 32'h2);
        @(posedge clk);
        mac_evt <= 5'h02;
        phy_irq <= 1'b1;
        wr(wk_pkg::REG_PWR_CTRL, 32'h23);
        rd(wk_pkg::REG_PWR_CTRL);
        chk(d, 32'h23, "clear refused while active");
        mac_evt <= 5'h00;
        phy_irq <= 1'b0;
        wr(wk_pkg::REG_PWR_CTRL, 32'h23);
        rd(wk_pkg::REG_PWR_CTRL);
        chk(d, 32'h20, "status cleared");
        for (int k = 0; k < 5; k++) begin
            wr(wk_pkg::REG_MAC_WAKE, 32'h1e0 | (32'h1 << k));
            @(posedge clk);
            mac_evt <= 5'h1f ^ (5'h1 << k);
            @(posedge clk);
            mac_evt <= 5'h00;
            rd(wk_pkg::REG_PWR_CTRL);
            chk(d, 32'h20, "masked mac event");
            wr(wk_pkg::REG_MAC_WAKE, 32'h1e0 | (32'h1 << k));
            @(posedge clk);
            mac_evt <= 5'h1 << k;
            @(posedge clk);
            mac_evt <= 5'h00;
            rd(wk_pkg::REG_PWR_CTRL);
            chk(d, 32'h22, "enabled mac event");
            rd(wk_pkg::REG_MAC_WAKE);
            chk(d, (32'h1 << k) | SEEN[k], "seen flag");
            wr(wk_pkg::REG_PWR_CTRL, 32'h22);
        end
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 5; k++) trial(2'(m), k);
        end
        w0 = wakes;
        host_pulse(1'b0);
        tick(3);
        chk(32'(wakes - w0), 32'h1, "left pin status wakes at once");
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end
endmodule
